// [design/cap_slot_mem.sv]
// Dedicated touch key data memory holding capacitor codes per module and slot
`timescale 1ns/10ps
`default_nettype none
module cap_slot_mem
    import touch_cfg_pkg::*;
#(
    parameter int WIDTH  = 10,
    parameter int ADDR_W = 4
) (
    input  wire logic              clk_sys,  // System clock
    input  wire logic              wrEn,     // Write strobe
    input  wire logic [ADDR_W-1:0] wrAddr,   // Write address
    input  wire logic [WIDTH-1:0]  wrData,   // Write data
    input  wire logic [ADDR_W-1:0] rdAddr,   // Read address
    output logic      [WIDTH-1:0]  rdData    // Registered read data
);
    logic [WIDTH-1:0] mem [2**ADDR_W];
    logic [WIDTH-1:0] rdData_ff;

    // No reset: contents are loaded by the scan side before use
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_ff <= mem[rdAddr];
    end

    assign rdData = rdData_ff;
endmodule
`default_nettype wire

// [design/touch_cfg_pkg.sv]
// Package: register map, field layout and types of the touch reference/hop control block
package touch_cfg_pkg;
    localparam int          N_MODULES      = 4;
    localparam int          CAP_W          = 10;
    localparam int          HOP_W          = 3;
    localparam int          SLOT_W         = 2;
    // Register map: three word registers per module, module stride 0x10
    localparam logic [11:0] OFF_CAP_HIGH   = 12'h000;
    localparam logic [11:0] OFF_CAP_LOW    = 12'h004;
    localparam logic [11:0] OFF_FREQ_CTRL  = 12'h008;
    localparam int          MOD_STRIDE_LSB = 4;
    localparam logic [1:0]  HSIZE_WORD     = 2'h2;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    // Field positions in module_freq_control
    localparam int          POS_DOUBLE     = 5;
    localparam int          POS_TEST       = 4;
    localparam int          POS_HOPSEL     = 3;
    localparam logic [7:0]  CTRL_MASK      = 8'h3F;
    localparam logic [7:0]  CAPH_MASK      = 8'h03;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    // Capacitance scale: code * 50 pF / 1024
    localparam int          CAP_FULL_PF    = 50;
    localparam int          CAP_DIV        = 1024;
    localparam int          CAP_FF_W       = 16;

    typedef struct packed {
        logic             freqDoubleEn;
        logic             testOnlyBit;
        logic             hopCtrlSelect;
        logic [HOP_W-1:0] hopFreqSelect;
    } freq_ctrl_t;

    // Drive towards the analog oscillators of one module
    typedef struct packed {
        logic [CAP_W-1:0] refCapCode;
        logic [15:0]      refCapFf;    // Capacitance in femtofarads
        logic             keyDouble;
        logic             hopHw;
        logic [HOP_W-1:0] hopCode;
    } osc_drive_t;
endpackage

// [design/touch_ref_cap_and_hop_control.sv]
// Top: per-module reference capacitor and hop control registers on AHB-Lite
`timescale 1ns/10ps
`default_nettype none
module touch_ref_cap_and_hop_control
    import touch_cfg_pkg::*;
#(
    parameter int NMOD = N_MODULES
) (
    input  wire logic                    clk_sys,     // 50 MHz system clock
    input  wire logic                    resetn,      // Async reset, low
    input  wire logic                    hsel,        // AHB slave select
    input  wire logic [31:0]             haddr,       // AHB address
    input  wire logic [1:0]              htrans,      // AHB transfer type
    input  wire logic                    hwrite,      // AHB write
    input  wire logic [2:0]              hsize,       // AHB size
    input  wire logic [31:0]             hwdata,      // AHB write data
    input  wire logic                    hready,      // AHB ready in
    output logic      [31:0]             hrdata,      // AHB read data
    output logic                         hreadyout,   // AHB ready out
    output logic                         hresp,       // AHB response
    input  wire logic                    autoScan,    // Auto scan mode
    input  wire logic                    slotEnd,     // Time slot end pulse
    input  wire logic [SLOT_W-1:0]       nextSlot,    // Slot about to start
    input  wire logic                    memWrEn,     // Data memory write
    input  wire logic [$clog2(NMOD)+SLOT_W-1:0] memWrAddr, // Memory address
    input  wire logic [CAP_W-1:0]        memWrData,   // Memory write data
    output osc_drive_t [NMOD-1:0]        oscDrive     // Oscillator controls
);
    localparam int MW = $clog2(NMOD);
    localparam int AW = MW + SLOT_W;
    // Code shown while hardware owns hopping; the hop sequence is outside
    localparam logic [HOP_W-1:0] HOP_NOMINAL = 3'h4;

    // Address phase decode
    logic             take;
    logic             takeRd;
    logic             takeInMap;
    logic [MW-1:0]    takeMod;
    logic [3:0]       takeReg;

    // Data phase of a write: address kept until the data arrives
    logic             pendWr_ff, nxt_pendWr;
    logic [11:0]      pendAddr_ff, nxt_pendAddr;
    logic             pendInMap;
    logic [MW-1:0]    pendMod;
    logic [3:0]       pendReg;

    // Read data register and the word each module offers
    logic [31:0]      hrdata_ff, nxt_hrdata;
    logic [31:0]      rdWord [NMOD];

    // Auto scan reload: memory answers one cycle after slot end
    logic             loadPend_ff, nxt_loadPend;
    logic [CAP_W-1:0] memRd [NMOD];

    // Address bits above 11 are not decoded, so the map repeats
    assign take      = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign takeRd    = take && !hwrite;
    assign takeMod   = haddr[MOD_STRIDE_LSB +: MW];
    assign takeReg   = haddr[3:0];
    assign takeInMap = (haddr[11:MOD_STRIDE_LSB+MW] == '0)
                       && (int'(takeMod) < NMOD);
    assign pendMod   = pendAddr_ff[MOD_STRIDE_LSB +: MW];
    assign pendReg   = pendAddr_ff[3:0];
    assign pendInMap = (pendAddr_ff[11:MOD_STRIDE_LSB+MW] == '0)
                       && (int'(pendMod) < NMOD);

    always_comb begin
        nxt_pendWr   = take && hwrite;
        nxt_pendAddr = take ? haddr[11:0] : pendAddr_ff;
        nxt_hrdata   = hrdata_ff;
        if (takeRd) begin
            // Unmapped slots read as zero
            nxt_hrdata = 32'h0000_0000;
            if (takeInMap) begin
                nxt_hrdata = rdWord[takeMod];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pendWr_ff   <= 1'b0;
            pendAddr_ff <= 12'h000;
            hrdata_ff   <= 32'h0000_0000;
        end else begin
            pendWr_ff   <= nxt_pendWr;
            pendAddr_ff <= nxt_pendAddr;
            hrdata_ff   <= nxt_hrdata;
        end
    end

    // nextSlot must be valid in the same cycle as slotEnd
    always_comb begin
        nxt_loadPend = autoScan && slotEnd;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loadPend_ff <= 1'b0;
        end else begin
            loadPend_ff <= nxt_loadPend;
        end
    end

    // hrdata stands until the next read address phase
    assign hrdata    = hrdata_ff;
    // No wait states and no errors; hsize is not checked, all words
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    genvar g;
    generate
        for (g = 0; g < NMOD; g++) begin : g_mod
            logic [CAP_W-1:0] cap_ff, nxt_cap;
            freq_ctrl_t       ctrl_ff, nxt_ctrl;
            logic             memWrHere;
            logic             busWrHere;
            logic [15:0]      capFf;

            assign memWrHere = memWrEn && (memWrAddr[AW-1:SLOT_W] == MW'(g));
            assign busWrHere = pendWr_ff && pendInMap
                               && (pendMod == MW'(g));

            // Per-module slice of the data memory, indexed by slot
            cap_slot_mem #(
                .WIDTH  (CAP_W),
                .ADDR_W (SLOT_W)
            ) u_mem (
                .clk_sys (clk_sys),
                .wrEn    (memWrHere),
                .wrAddr  (memWrAddr[SLOT_W-1:0]),
                .wrData  (memWrData),
                .rdAddr  (nextSlot),
                .rdData  (memRd[g])
            );

            always_comb begin
                nxt_cap  = cap_ff;
                nxt_ctrl = ctrl_ff;
                if (loadPend_ff) begin
                    nxt_cap = memRd[g];
                end
                // Software write lands after a reload in the same cycle
                if (busWrHere) begin
                    case (pendReg)
                        OFF_CAP_HIGH[3:0]: begin
                            nxt_cap[9:8] = hwdata[1:0];
                        end
                        OFF_CAP_LOW[3:0]: begin
                            nxt_cap[7:0] = hwdata[7:0];
                        end
                        // Test-only bit is stored and read back, drives nothing
                        OFF_FREQ_CTRL[3:0]: begin
                            nxt_ctrl = freq_ctrl_t'(hwdata[5:0]);
                        end
                        default: ;
                    endcase
                end
            end

            // Each module owns its copy; nothing is shared between modules
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    cap_ff  <= '0;
                    ctrl_ff <= freq_ctrl_t'(RESET_BYTE[5:0]);
                end else begin
                    cap_ff  <= nxt_cap;
                    ctrl_ff <= nxt_ctrl;
                end
            end

            // Built from the next values, so a read right behind a write
            // returns the data just written
            always_comb begin
                rdWord[g] = 32'h0000_0000;
                case (takeReg)
                    OFF_CAP_HIGH[3:0]: begin
                        rdWord[g] = {24'h0, 6'h00, nxt_cap[9:8]};
                    end
                    OFF_CAP_LOW[3:0]: begin
                        rdWord[g] = {24'h0, nxt_cap[7:0]};
                    end
                    OFF_FREQ_CTRL[3:0]: begin
                        rdWord[g] = {24'h0, 2'h0, nxt_ctrl};
                    end
                    default: begin
                        rdWord[g] = 32'h0000_0000;
                    end
                endcase
            end

            // Femtofarads: code * 50000 / 1024, kept to 16 bits
            assign capFf = 16'((32'(cap_ff) * 32'(CAP_FULL_PF) * 32'd1000)
                               / 32'(CAP_DIV));

            always_comb begin
                oscDrive[g].refCapCode = cap_ff;
                oscDrive[g].refCapFf   = capFf;
                oscDrive[g].keyDouble  = ctrl_ff.freqDoubleEn;
                oscDrive[g].hopHw      = ctrl_ff.hopCtrlSelect;
                // Code passes straight through while hopCtrlSelect is 0: 000 min, 100 nominal, 111 max
                oscDrive[g].hopCode    = ctrl_ff.hopFreqSelect;
                if (ctrl_ff.hopCtrlSelect) begin
                    oscDrive[g].hopCode = HOP_NOMINAL;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [testbench/touch_cfg_props.sv]
// Checker: bus read-back and oscillator drive properties of the block
`timescale 1ns/10ps
`default_nettype none
module touch_cfg_props
    import touch_cfg_pkg::*;
#(
    parameter int NMOD = N_MODULES
) (
    input wire logic                  clk_sys,  // Clock
    input wire logic                  resetn,   // Reset, low
    input wire logic                  hsel,     // Select
    input wire logic [31:0]           haddr,    // Address
    input wire logic [1:0]            htrans,   // Transfer
    input wire logic                  hwrite,   // Write
    input wire logic                  hready,   // Ready in
    input wire logic [31:0]           hrdata,   // Read data
    input wire logic                  autoScan, // Auto scan
    input wire logic                  slotEnd,  // Slot end
    input wire osc_drive_t [NMOD-1:0] oscDrive  // Oscillator drive
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic wr0  = take && hwrite && haddr[5:4] == 2'h0;
    wire logic wr1  = take && hwrite && haddr[5:4] == 2'h1;
    // Reload and write both take two edges: cause sampled on the first, code updated on the second
    wire logic c0   = wr0 || (autoScan && slotEnd);
    wire logic c1   = wr1 || (autoScan && slotEnd);
    sequence s_rdHigh; take && !hwrite && haddr[3:0] == 4'h0; endsequence
    sequence s_rdCtrl; take && !hwrite && haddr[3:0] == 4'h8; endsequence
    sequence s_cause0; $past(c0, 2) || $past(c0, 3); endsequence
    sequence s_cause1; $past(c1, 2) || $past(c1, 3); endsequence
    property p_resetClear; $rose(resetn) |-> oscDrive == '0; endproperty
    a_resetClear: assert property (p_resetClear) else $error("reset");
    property p_capScale; oscDrive[0].refCapFf ==
        16'((32'(oscDrive[0].refCapCode) * 50000) / 1024); endproperty
    a_capScale: assert property (p_capScale) else $error("scale");
    property p_hwNominal;
        oscDrive[0].hopHw |-> oscDrive[0].hopCode == 3'h4; endproperty
    a_hwNominal: assert property (p_hwNominal) else $error("hw hop");
    property p_rdHighZero; s_rdHigh |=> hrdata[31:2] == 30'h0; endproperty
    a_rdHighZero: assert property (p_rdHighZero) else $error("high");
    property p_rdCtrlZero; s_rdCtrl |=> hrdata[31:6] == 26'h0; endproperty
    a_rdCtrlZero: assert property (p_rdCtrlZero) else $error("ctrl");
    property p_capCause;
        !$stable(oscDrive[0].refCapCode) |-> s_cause0; endproperty
    a_capCause: assert property (p_capCause) else $error("cap0");
    property p_dblCause; !$stable(oscDrive[0].keyDouble) |->
        $past(wr0, 2) || $past(wr0, 3); endproperty
    a_dblCause: assert property (p_dblCause) else $error("double");
    property p_mod1Cause;
        !$stable(oscDrive[1].refCapCode) |-> s_cause1; endproperty
    a_mod1Cause: assert property (p_mod1Cause) else $error("cap1");
endmodule
bind touch_ref_cap_and_hop_control touch_cfg_props #(.NMOD(NMOD)) u_props (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .autoScan(autoScan), .slotEnd(slotEnd), .oscDrive(oscDrive));
`default_nettype wire

// [testbench/touch_ref_cap_and_hop_control_tb_top.sv]
// Testbench: register, hop and reload scenarios of the block
`timescale 1ns/10ps
`default_nettype none
module touch_ref_cap_and_hop_control_tb_top;
    import touch_cfg_pkg::*;
    logic             clk_sys, resetn, hsel, hwrite, autoScan, slotEnd;
    logic             memWrEn, hreadyout, hresp;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [1:0]       htrans, nextSlot;
    logic [3:0]       memWrAddr;
    logic [CAP_W-1:0] memWrData;
    osc_drive_t [3:0] oscDrive;
    int               err_count, checked, cycles;
    touch_ref_cap_and_hop_control dut (
        .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize({1'b0, HSIZE_WORD}),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .autoScan(autoScan),
        .slotEnd(slotEnd), .nextSlot(nextSlot), .memWrEn(memWrEn),
        .memWrAddr(memWrAddr), .memWrData(memWrData), .oscDrive(oscDrive));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 12; i++) begin
            ahb(1'b0, 32'((i / 3) * 16 + (i % 3) * 4), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        chk("drive reset", 32'h0, 32'(oscDrive[3]));
        $display("done reset");
    endtask
    task automatic t_cap();
        ahb(1'b1, 32'h020, 32'hFFFF_FFFF);
        ahb(1'b1, 32'h024, 32'h0000_00A5);
        ahb(1'b0, 32'h020, 32'h0);
        chk("cap high", 32'h3, rd);
        chk("resp okay", 32'h0, 32'(hresp));
        chk("cap code", 32'h3A5, 32'(oscDrive[2].refCapCode));
        chk("cap fF", 32'h3A5 * 50000 / 1024, 32'(oscDrive[2].refCapFf));
        chk("other module", 32'h0, 32'(oscDrive[1].refCapCode));
        ahb(1'b0, 32'h00C, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("done cap");
    endtask
    task automatic t_ctrl();
        ahb(1'b1, 32'h008, 32'h0000_00EF);
        ahb(1'b0, 32'h008, 32'h0);
        chk("ctrl read", 32'h2F, rd);
        chk("double on", 32'h1, 32'(oscDrive[0].keyDouble));
        chk("hw hop", 32'h4, 32'(oscDrive[0].hopCode));
        for (int k = 0; k < 8; k++) begin
            ahb(1'b1, 32'h008, 32'(k));
            chk("sw hop", 32'(k), 32'(oscDrive[0].hopCode));
            chk("sw select", 32'h0, 32'(oscDrive[0].hopHw));
        end
        chk("double off", 32'h0, 32'(oscDrive[0].keyDouble));
        $display("done ctrl");
    endtask
    task automatic t_auto();
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            autoScan <= 1'b1;
            memWrEn <= 1'b1;
            memWrAddr <= 4'(m * 4 + 2);
            memWrData <= 10'(m * 16 + 10'h2C3);
        end
        @(posedge clk_sys);
        memWrEn <= 1'b0;
        slotEnd <= 1'b1;
        nextSlot <= 2'h2;
        @(posedge clk_sys);
        slotEnd <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("reload", 32'h2D3, 32'(oscDrive[1].refCapCode));
        ahb(1'b0, 32'h014, 32'h0);
        chk("reload low", 32'hD3, rd);
        $display("done auto");
    endtask
    initial begin
        {resetn, hsel, hwrite, autoScan, slotEnd, memWrEn} = 6'h00;
        {haddr, hwdata, htrans, nextSlot, memWrAddr, memWrData} = '0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_cap();
        t_ctrl();
        t_auto();
        results();
    end
endmodule
`default_nettype wire
